// file: transceiver_config_sleep_regs.sv
// configuration, state and sleep registers of bank 3 with clock outputs
`timescale 1ns/10ps
module transceiver_config_sleep_regs #(
    parameter int FAST_HALF = 1,
    parameter int SLOW_HALF = 2,
    parameter int CODEC_HALF = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] bank_sel,
    input wire logic [2:0] ext_addr,
    input wire logic ext_wr,
    input wire logic ext_rd,
    input wire logic [15:0] ext_wdata,
    output logic [15:0] ext_rdata,
    input wire logic wake_pin,
    input wire logic frame_tick,
    input wire logic hop_event,
    input wire logic antenna_tick,
    input wire logic acq_event,
    input wire logic frame_begin_event,
    output logic voice_proc_clock_pin,
    output logic codec_clock_pin,
    output logic hop_pulse_pin,
    output logic diversity_select_a,
    output logic diversity_select_b,
    output logic [6:0] diversity_switch_advance,
    output logic rf_front_end_on,
    output logic doze_active,
    output logic acquisition_flag,
    output logic frame_begin_flag,
    output logic bias_source_sw,
    output logic [4:0] search_window_bits,
    output logic [12:0] bias_threshold_ext,
    output xcvr_cfg_pkg::state_ctrl_s state_ctrl
);
    // -----------------------------------------------------------------
    // register file
    // -----------------------------------------------------------------
    xcvr_cfg_pkg::rx_cfg_a_s cfg_a_q, cfg_a_d;
    xcvr_cfg_pkg::ant_sleep_s ant_q, ant_d;
    xcvr_cfg_pkg::state_ctrl_s st_q, st_d;
    logic [15:0] rdata_q, rdata_d;
    logic [7:0] frames_left_q, frames_left_d;
    logic wr_a, wr_ant, wr_st, rd_hit;
    logic cmd_rise;

    function automatic logic hit(input logic [1:0] bank, input logic [2:0] a,
                                 input logic [2:0] want);
        hit = (bank == xcvr_cfg_pkg::BANK_THIS) && (a == want);
    endfunction

    assign wr_a = ext_wr && hit(bank_sel, ext_addr, xcvr_cfg_pkg::ADDR_RX_CFG_A);
    assign wr_ant = ext_wr && hit(bank_sel, ext_addr, xcvr_cfg_pkg::ADDR_ANT_SLEEP);
    assign wr_st = ext_wr && hit(bank_sel, ext_addr, xcvr_cfg_pkg::ADDR_STATE_CTRL);
    assign rd_hit = ext_rd && (bank_sel == xcvr_cfg_pkg::BANK_THIS);

    xcvr_cfg_pkg::state_ctrl_s wst;
    assign wst = xcvr_cfg_pkg::state_ctrl_s'(ext_wdata);
    assign cmd_rise = wr_st && wst.doze_command && !st_q.doze_command;

    always_comb
    begin
        cfg_a_d = cfg_a_q;
        ant_d = ant_q;
        st_d = st_q;
        rdata_d = rdata_q;
        if (wr_a)
            cfg_a_d = xcvr_cfg_pkg::rx_cfg_a_s'(ext_wdata);
        if (wr_ant)
            ant_d = xcvr_cfg_pkg::ant_sleep_s'(ext_wdata);
        if (wr_st)
            st_d = wst;
        if (rd_hit)
        begin
            unique case (ext_addr)
                xcvr_cfg_pkg::ADDR_ANT_SLEEP:
                    rdata_d = {8'h00, frames_left_q};
                xcvr_cfg_pkg::ADDR_STATE_CTRL:
                    rdata_d = st_q;
                default:
                    rdata_d = xcvr_cfg_pkg::READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cfg_a_q <= xcvr_cfg_pkg::RX_CFG_A_RESET;
            ant_q <= xcvr_cfg_pkg::ANT_SLEEP_RESET;
            st_q <= xcvr_cfg_pkg::STATE_CTRL_RESET;
            rdata_q <= xcvr_cfg_pkg::READ_ZERO;
        end
        else
        begin
            cfg_a_q <= cfg_a_d;
            ant_q <= ant_d;
            st_q <= st_d;
            rdata_q <= rdata_d;
        end
    end

    assign ext_rdata = rdata_q;
    assign state_ctrl = st_q;
    assign bias_source_sw = cfg_a_q.bias_source_sw;
    assign search_window_bits = {cfg_a_q.window_code, 1'b1};
    assign bias_threshold_ext = {{(xcvr_cfg_pkg::THRESH_EXT_W - 8){cfg_a_q.bias_threshold[7]}},
                                 cfg_a_q.bias_threshold};
    assign diversity_switch_advance = ant_q.diversity_switch_advance;

    // -----------------------------------------------------------------
    // status flags
    // -----------------------------------------------------------------
    logic acq_q, acq_d, fb_q, fb_d;
    logic acq_clr, fb_clr;
    assign acq_clr = wr_st && st_q.acquisition_flag_clear && !wst.acquisition_flag_clear;
    assign fb_clr = wr_st && st_q.frame_begin_clear && !wst.frame_begin_clear;

    always_comb
    begin
        // set beats a clear landing in the same cycle
        acq_d = acq_event || (acq_q && !acq_clr);
        fb_d = frame_begin_event || (fb_q && !fb_clr);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acq_q <= 1'b0;
            fb_q <= 1'b0;
        end
        else
        begin
            acq_q <= acq_d;
            fb_q <= fb_d;
        end
    end

    assign acquisition_flag = acq_q;
    assign frame_begin_flag = fb_q;

    // -----------------------------------------------------------------
    // sleep sequencer
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {AWAKE, DOZING, KEY_WOKEN} doze_e;
    doze_e doze_q, doze_d;
    logic [7:0] count_q, count_d;
    logic wake_s1_q, wake_s2_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wake_s1_q <= 1'b0;
            wake_s2_q <= 1'b0;
        end
        else
        begin
            wake_s1_q <= wake_pin;
            wake_s2_q <= wake_s1_q;
        end
    end

    always_comb
    begin
        doze_d = doze_q;
        count_d = count_q;
        frames_left_d = frames_left_q;
        unique case (doze_q)
            AWAKE:
                if (cmd_rise && st_q.doze_permit)
                begin
                    doze_d = DOZING;
                    count_d = ant_q.doze_length;
                end
            DOZING:
                if (wake_s2_q)
                begin
                    doze_d = KEY_WOKEN;
                    frames_left_d = count_q;
                end
                else if (frame_tick)
                begin
                    if (count_q <= xcvr_cfg_pkg::DOZE_ONE)
                    begin
                        doze_d = AWAKE;
                        count_d = xcvr_cfg_pkg::DOZE_EXPIRED;
                        frames_left_d = xcvr_cfg_pkg::DOZE_EXPIRED;
                    end
                    else
                        count_d = count_q - 8'h01;
                end
            KEY_WOKEN:
                if (!wake_s2_q)
                    // permission left set means straight back to sleep
                    doze_d = st_q.doze_permit ? DOZING : AWAKE;
            default:
                doze_d = AWAKE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            doze_q <= AWAKE;
            count_q <= xcvr_cfg_pkg::DOZE_EXPIRED;
            frames_left_q <= xcvr_cfg_pkg::DOZE_EXPIRED;
        end
        else
        begin
            doze_q <= doze_d;
            count_q <= count_d;
            frames_left_q <= frames_left_d;
        end
    end

    assign doze_active = (doze_q == DOZING);
    assign rf_front_end_on = (doze_q == DOZING);

    // -----------------------------------------------------------------
    // clock outputs, hop pulse, antenna diversity
    // -----------------------------------------------------------------
    logic vclk_q, vclk_d, cclk_q, cclk_d;
    logic [2:0] vcnt_q, vcnt_d, ccnt_q, ccnt_d;
    logic hop_q, hop_d, ant_sel_q, ant_sel_d;
    logic [2:0] vhalf;

    // half length sampled each cycle, so a rate change lands on a whole half-period
    assign vhalf = cfg_a_q.proc_clock_rate_sel ? 3'(SLOW_HALF) : 3'(FAST_HALF);

    always_comb
    begin
        vclk_d = vclk_q;
        vcnt_d = vcnt_q + 3'h1;
        if (vcnt_q + 3'h1 >= vhalf)
        begin
            vcnt_d = 3'h0;
            // freezing only stops the high-to-low edge, so no short pulse
            if (!(vclk_q && st_q.voice_proc_clock_freeze))
                vclk_d = !vclk_q;
        end
        cclk_d = cclk_q;
        ccnt_d = ccnt_q + 3'h1;
        if (ccnt_q + 3'h1 >= 3'(CODEC_HALF))
        begin
            ccnt_d = 3'h0;
            if (!(cclk_q && st_q.codec_clock_freeze && doze_active))
                cclk_d = !cclk_q;
        end
        hop_d = (hop_event && st_q.hop_enable) ^ cfg_a_q.hop_pulse_polarity;
        ant_sel_d = ant_sel_q;
        if (antenna_tick && !ant_q.diversity_switch_disable)
            ant_sel_d = !ant_sel_q;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vclk_q <= 1'b0;
            cclk_q <= 1'b0;
            vcnt_q <= 3'h0;
            ccnt_q <= 3'h0;
            hop_q <= 1'b0;
            ant_sel_q <= 1'b0;
        end
        else
        begin
            vclk_q <= vclk_d;
            cclk_q <= cclk_d;
            vcnt_q <= vcnt_d;
            ccnt_q <= ccnt_d;
            hop_q <= hop_d;
            ant_sel_q <= ant_sel_d;
        end
    end

    assign voice_proc_clock_pin = vclk_q;
    assign codec_clock_pin = cclk_q;
    assign hop_pulse_pin = hop_q;
    assign diversity_select_a = !ant_sel_q;
    assign diversity_select_b = ant_sel_q;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    a_cfg_reads_zero: assert property (@(posedge clk) disable iff (!rst_n)
        rd_hit && ext_addr == xcvr_cfg_pkg::ADDR_RX_CFG_A |=> ext_rdata == 16'h0000)
        else $error("config read not zero");
    a_flag_clear_edge: assert property (@(posedge clk) disable iff (!rst_n)
        acq_clr && !acq_event |=> !acquisition_flag)
        else $error("acquisition flag not cleared");
    a_flag_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        acq_event |=> acquisition_flag)
        else $error("acquisition event lost");
    a_doze_needs_permit: assert property (@(posedge clk) disable iff (!rst_n)
        doze_q == AWAKE && !st_q.doze_permit |=> doze_q == AWAKE)
        else $error("sleep entered without permission");
    a_doze_entry: assert property (@(posedge clk) disable iff (!rst_n)
        doze_q == AWAKE && cmd_rise && st_q.doze_permit |=> doze_active
        && count_q == $past(ant_q.doze_length))
        else $error("sleep command not taken");
    a_wake_capture: assert property (@(posedge clk) disable iff (!rst_n)
        doze_active && wake_s2_q |=> doze_q == KEY_WOKEN && frames_left_q == $past(count_q))
        else $error("wake count not captured");
    a_resleep_permit: assert property (@(posedge clk) disable iff (!rst_n)
        doze_q == KEY_WOKEN && !wake_s2_q && st_q.doze_permit |=> doze_active)
        else $error("did not return to sleep");
    // four cycles of freeze leave room for one slow half-period to finish
    a_vclk_freeze: assert property (@(posedge clk) disable iff (!rst_n)
        st_q.voice_proc_clock_freeze[*4] |-> voice_proc_clock_pin)
        else $error("voice clock not frozen high");
    a_vclk_width: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(voice_proc_clock_pin) && cfg_a_q.proc_clock_rate_sel |=> voice_proc_clock_pin)
        else $error("voice clock runt");
    a_hop_polarity: assert property (@(posedge clk) disable iff (!rst_n)
        !hop_event |=> hop_pulse_pin == $past(cfg_a_q.hop_pulse_polarity))
        else $error("hop idle level wrong");
    a_ant_hold: assert property (@(posedge clk) disable iff (!rst_n)
        ant_q.diversity_switch_disable |=> $stable(diversity_select_a))
        else $error("antenna switched while disabled");

    c_doze_expire: cover property (@(posedge clk) disable iff (!rst_n)
        doze_active ##1 doze_q == AWAKE);
    c_key_wake: cover property (@(posedge clk) disable iff (!rst_n)
        doze_q == KEY_WOKEN ##1 doze_active);
    c_flag_clear: cover property (@(posedge clk) disable iff (!rst_n)
        acquisition_flag ##1 !acquisition_flag);
endmodule // transceiver_config_sleep_regs

// file: transceiver_config_sleep_regs_tb_top.sv
// self-checking testbench for the transceiver configuration and sleep bank
`timescale 1ns/10ps
module transceiver_config_sleep_regs_tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] bank_sel = 2'h0;
    logic [2:0] ext_addr = 3'h0;
    logic ext_wr = 1'b0;
    logic ext_rd = 1'b0;
    logic [15:0] ext_wdata = 16'h0000;
    logic [15:0] ext_rdata;
    logic wake_pin = 1'b0;
    logic frame_tick = 1'b0;
    logic hop_event = 1'b0;
    logic antenna_tick = 1'b0;
    logic acq_event = 1'b0;
    logic frame_begin_event = 1'b0;
    logic voice_proc_clock_pin, codec_clock_pin, hop_pulse_pin;
    logic diversity_select_a, diversity_select_b, rf_front_end_on, doze_active;
    logic acquisition_flag, frame_begin_flag, bias_source_sw;
    logic [6:0] diversity_switch_advance;
    logic [4:0] search_window_bits;
    logic [12:0] bias_threshold_ext;
    xcvr_cfg_pkg::state_ctrl_s state_ctrl;
    int num_errors = 0;
    int checks = 0;
    logic [15:0] rd_val;
    int n;

    always #5 clk = ~clk;

    transceiver_config_sleep_regs #(.FAST_HALF(1), .SLOW_HALF(2), .CODEC_HALF(4)) u_dut (
        .clk(clk), .rst_n(rst_n), .bank_sel(bank_sel), .ext_addr(ext_addr),
        .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
        .wake_pin(wake_pin), .frame_tick(frame_tick), .hop_event(hop_event),
        .antenna_tick(antenna_tick), .acq_event(acq_event),
        .frame_begin_event(frame_begin_event), .voice_proc_clock_pin(voice_proc_clock_pin),
        .codec_clock_pin(codec_clock_pin), .hop_pulse_pin(hop_pulse_pin),
        .diversity_select_a(diversity_select_a), .diversity_select_b(diversity_select_b),
        .diversity_switch_advance(diversity_switch_advance),
        .rf_front_end_on(rf_front_end_on), .doze_active(doze_active),
        .acquisition_flag(acquisition_flag), .frame_begin_flag(frame_begin_flag),
        .bias_source_sw(bias_source_sw), .search_window_bits(search_window_bits),
        .bias_threshold_ext(bias_threshold_ext), .state_ctrl(state_ctrl)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("errors %0d, comparisons %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [1:0] bank, input logic [2:0] addr, input logic [15:0] d);
        @(negedge clk);
        bank_sel = bank;
        ext_addr = addr;
        ext_wdata = d;
        ext_wr = 1'b1;
        @(negedge clk);
        ext_wr = 1'b0;
    endtask

    task automatic rd(input logic [2:0] addr);
        @(negedge clk);
        bank_sel = 2'h3;
        ext_addr = addr;
        ext_rd = 1'b1;
        @(negedge clk);
        ext_rd = 1'b0;
        @(negedge clk);
        rd_val = ext_rdata;
    endtask

    // strobe one event input for a single cycle
    task automatic pulse(input int which);
        @(negedge clk);
        case (which)
            0: frame_tick = 1'b1;
            1: hop_event = 1'b1;
            2: antenna_tick = 1'b1;
            3: acq_event = 1'b1;
            default: frame_begin_event = 1'b1;
        endcase
        @(negedge clk);
        {frame_tick, hop_event, antenna_tick, acq_event, frame_begin_event} = 5'h00;
    endtask

    // wake is synchronised, so the state change lags by a few cycles
    task automatic wait_doze(input logic lvl);
        int i;
        for (i = 0; i < 20 && doze_active !== lvl; i++)
            @(negedge clk);
        if (doze_active !== lvl)
        begin
            num_errors++;
            $display("mismatch at %0t: doze state wait ran out", $time);
            final_report();
        end
    endtask

    // cycles between two consecutive edges of the voice processor clock
    task automatic half_len(output int len);
        logic p;
        int i;
        p = voice_proc_clock_pin;
        for (i = 0; i < 20 && voice_proc_clock_pin === p; i++)
            @(negedge clk);
        p = voice_proc_clock_pin;
        len = 0;
        for (i = 0; i < 20 && voice_proc_clock_pin === p; i++)
        begin
            @(negedge clk);
            len++;
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(3'h0);
        chk(rd_val, 16'h0000);
        rd(3'h1);
        chk(rd_val, 16'h0000);
        rd(3'h2);
        chk(rd_val, 16'h0000);
        chk(16'(diversity_select_a), 16'h0001);
    endtask

    task automatic t_config();
        wr(2'h3, 3'h0, 16'hBFD3);
        chk(16'(bias_source_sw), 16'h0001);
        chk(16'(search_window_bits), 16'h001F);
        chk(16'(bias_threshold_ext), 16'h1FD3);
        rd(3'h0);
        chk(rd_val, 16'h0000);
        wr(2'h3, 3'h0, 16'h8000);
        chk(16'(search_window_bits), 16'h0001);
        chk(16'(bias_source_sw), 16'h0000);
        half_len(n);
        chk(16'(n), 16'h0001);
        wr(2'h3, 3'h0, 16'hC000);
        half_len(n);
        chk(16'(n), 16'h0002);
    endtask

    task automatic t_state();
        logic [15:0] v;
        wr(2'h3, 3'h2, 16'hFFF6);
        rd(3'h2);
        chk(rd_val, 16'hFFF6);
        chk(16'(state_ctrl.tx_enable), 16'h0001);
        repeat (4) @(negedge clk);
        repeat (6)
        begin
            @(negedge clk);
            chk(16'(voice_proc_clock_pin), 16'h0001);
        end
        for (int m = 0; m < 4; m++)
        begin
            v = 16'h0000 | 16'(m << 1);
            wr(2'h3, 3'h2, v);
            rd(3'h2);
            chk(rd_val, v);
        end
        // another bank must leave this one alone
        wr(2'h2, 3'h2, 16'hFFF6);
        chk(16'(state_ctrl), 16'h0006);
    endtask

    task automatic t_hop_ant();
        wr(2'h3, 3'h2, 16'h0040);
        pulse(1);
        chk(16'(hop_pulse_pin), 16'h0001);
        wr(2'h3, 3'h0, 16'h9000);
        @(negedge clk);
        chk(16'(hop_pulse_pin), 16'h0001);
        pulse(1);
        chk(16'(hop_pulse_pin), 16'h0000);
        wr(2'h3, 3'h2, 16'h0000);
        pulse(1);
        chk(16'(hop_pulse_pin), 16'h0001);
        wr(2'h3, 3'h1, 16'h6B03);
        chk(16'(diversity_switch_advance), 16'h006B);
        pulse(2);
        chk(16'({diversity_select_a, diversity_select_b}), 16'h0001);
        wr(2'h3, 3'h1, 16'hEB03);
        pulse(2);
        chk(16'({diversity_select_a, diversity_select_b}), 16'h0001);
    endtask

    task automatic t_flags();
        pulse(3);
        pulse(4);
        chk(16'({acquisition_flag, frame_begin_flag}), 16'h0003);
        wr(2'h3, 3'h2, 16'h0030);
        wr(2'h3, 3'h2, 16'h0010);
        chk(16'({acquisition_flag, frame_begin_flag}), 16'h0001);
        rd(3'h2);
        chk(rd_val, 16'h0010);
        wr(2'h3, 3'h2, 16'h0000);
        chk(16'({acquisition_flag, frame_begin_flag}), 16'h0000);
        pulse(3);
        wr(2'h3, 3'h2, 16'h0000);
        chk(16'(acquisition_flag), 16'h0001);
        wr(2'h3, 3'h2, 16'h0020);
        wr(2'h3, 3'h2, 16'h0000);
        chk(16'(acquisition_flag), 16'h0000);
    endtask

    task automatic t_sleep();
        wr(2'h3, 3'h1, 16'h0003);
        wr(2'h3, 3'h2, 16'h4008);
        wr(2'h3, 3'h2, 16'h4009);
        chk(16'({doze_active, rf_front_end_on}), 16'h0003);
        repeat (10) @(negedge clk);
        repeat (8)
        begin
            @(negedge clk);
            chk(16'(codec_clock_pin), 16'h0001);
        end
        pulse(0);
        pulse(0);
        chk(16'(doze_active), 16'h0001);
        pulse(0);
        chk(16'(doze_active), 16'h0000);
        rd(3'h1);
        chk(rd_val, 16'h0000);
        wr(2'h3, 3'h2, 16'h4008);
        wr(2'h3, 3'h2, 16'h4009);
        pulse(0);
        wake_pin = 1'b1;
        wait_doze(1'b0);
        rd(3'h1);
        chk(rd_val, 16'h0002);
        wake_pin = 1'b0;
        wait_doze(1'b1);
        chk(16'(doze_active), 16'h0001);
        wake_pin = 1'b1;
        wait_doze(1'b0);
        wr(2'h3, 3'h2, 16'h0000);
        wake_pin = 1'b0;
        repeat (6) @(negedge clk);
        chk(16'(doze_active), 16'h0000);
        wr(2'h3, 3'h2, 16'h0001);
        chk(16'(doze_active), 16'h0000);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_reset();
        t_config();
        t_state();
        t_hop_ant();
        t_flags();
        t_sleep();
        final_report();
    end
endmodule // transceiver_config_sleep_regs_tb_top

// file: xcvr_cfg_pkg.sv
// constants and types for the transceiver configuration and sleep bank
//
// What this block does
// - config bit e picks the voice processor clock rate: 0 fast, 1 half rate.
// - config bit d picks the oscillator offset: measured when 0, software when 1.
// - config bit c sets hop pulse polarity, 0 positive, 1 negative, at once.
// - bits b..8 set search window width as twice the field plus one.
// - low byte is a negative threshold, sign-extended to 13 bits for use.
// - second config bit f at 1 stops antenna select toggling.
// - bits e..8 advance antenna switching by that many cycles, kept below 108; the code passes all 7 bits through unclamped, up to 127.
// - low byte write sets sleep length in 4 ms frames, 1 to 255.
// - low byte read gives frames left when wake input ended sleep, 0 if expired.
// - state bit f enables fast synthesizer reload after sleep, reset 0.
// - state bit e holds the codec clock high during sleep when set.
// - state bit d holds the voice processor clock high when set, reset 0.
// - voice clock stops or restarts within two periods, keeping pulse widths.
// - state bit c picks bit-sync loop gain: nominal, or divided by 64.
// - state bit b lets the frequency loop update; cleared keeps last estimate.
// - state bit a globally enables transmit; reset disabled.
// - bits 8..7 pick search scope; bit 9 picks marker word or alternate pattern.
// - state bit 6 enables hop pulse emission on its pin.
// - bits 5 and 4 read back; a one-to-zero write clears their flag.
// - state bit 3 permits sleep; when 0 the sleep command does nothing.
// - wake input ending early with permission still set returns to sleep at once.
// - bits 2..1 set transceiver multiplexing mode; 10 reserved.
// - state bit 0 reads back; a zero-to-one write enters sleep.
package xcvr_cfg_pkg;
    // -----------------------------------------------------------------
    // register window
    // -----------------------------------------------------------------
    localparam logic [2:0] ADDR_RX_CFG_A = 3'h0;
    localparam logic [2:0] ADDR_ANT_SLEEP = 3'h1;
    localparam logic [2:0] ADDR_STATE_CTRL = 3'h2;
    localparam logic [1:0] BANK_THIS = 2'h3;
    localparam logic [15:0] RX_CFG_A_RESET = 16'h0000;
    localparam logic [15:0] ANT_SLEEP_RESET = 16'h0001;
    localparam logic [15:0] STATE_CTRL_RESET = 16'h0000;
    localparam logic [15:0] READ_ZERO = 16'h0000;
    localparam logic [7:0] DOZE_EXPIRED = 8'h00;
    localparam logic [7:0] DOZE_ONE = 8'h01;
    localparam int THRESH_EXT_W = 13;
    // -----------------------------------------------------------------
    // field layouts
    // -----------------------------------------------------------------
    typedef struct packed {
        logic must_be_one;
        logic proc_clock_rate_sel;
        logic bias_source_sw;
        logic hop_pulse_polarity;
        logic [3:0] window_code;
        logic [7:0] bias_threshold;
    } rx_cfg_a_s;
    typedef struct packed {
        logic diversity_switch_disable;
        logic [6:0] diversity_switch_advance;
        logic [7:0] doze_length;
    } ant_sleep_s;
    typedef struct packed {
        logic fast_synth_reload;
        logic codec_clock_freeze;
        logic voice_proc_clock_freeze;
        logic symbol_loop_gain_sel;
        logic bias_update_en;
        logic tx_enable;
        logic frame_marker_sel;
        logic [1:0] search_scope;
        logic hop_enable;
        logic acquisition_flag_clear;
        logic frame_begin_clear;
        logic doze_permit;
        logic [1:0] transceiver_mux_sel;
        logic doze_command;
    } state_ctrl_s;
    typedef enum logic [1:0] {SCOPE_NONE, SCOPE_WINDOW, SCOPE_FULL, SCOPE_UNUSED} search_scope_e;
    typedef enum logic [1:0] {
        PLAIN_MUX_MODE, INVERTING_MUX_MODE, MUX_RESERVED, FULL_ACCESS_MUX_MODE
    } transceiver_mux_e;
endpackage
